// File: src/fault_trap_cfg.svh
/*
  Constants for the fault and user trap unit: register offsets, field
  positions, reset values and vector ranges.
  Assumes it is included by bare name before any module that uses it.
*/
`ifndef FAULT_TRAP_CFG_SVH
`define FAULT_TRAP_CFG_SVH

// ==========================================================================
// Register offsets (byte addresses on the 32-bit register port)
`define OFF_CTRL        8'h00
`define OFF_FAULT_FLAG  8'h04
`define OFF_HANDLER     8'h08
`define OFF_STATUS      8'h0C

// ==========================================================================
// Field positions
`define CTRL_HALT_BIT   1
`define FF_MCHECK       0
`define FF_BAD_MEM      1
`define FF_BAD_REG_ID   2
`define FF_BAD_REG_VAL  3
`define FF_BAD_OP_VAL   4
`define FF_SOFTWARE_TRAP_INSTRUCTION_FAULT   13
`define FF_ID_LSB       24
`define ST_HALTED_BIT   0
`define ST_HANDLER_BIT  1

// ==========================================================================
// Reset values
`define CTRL_RESET      1'b0
`define HANDLER_RESET   32'h0000_0000

// ==========================================================================
// User-configurable vector range
`define USER_FIRST      8'h20
`define USER_LAST       8'h7F
`define USER_COUNT      96

`endif

// File: src/fault_trap_pkg.sv
/*
  Types for the fault and user trap unit.
  Assumes fault_trap_cfg.svh is compiled in the same unit.
*/
`include "fault_trap_cfg.svh"

package fault_trap_pkg;

  // ========================================================================
  // Execution mode of the core as seen by the fault logic
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_HANDLER,
    MODE_HALT
  } mode_t;

  // ========================================================================
  // State of the main module, except the fault flags held in sticky_flags
  typedef struct packed {
    mode_t                   mode;
    logic                    haltOnFault;
    logic [31:0]             handlerAddr;
    logic [7:0]              faultId;
    logic [`USER_COUNT-1:0]  vecValid;
    logic [`USER_COUNT-1:0]  vecBoth;
    logic [31:0]             rdData;
    logic                    trapTake;
    logic [6:0]              trapIdx;
    logic                    trapDenied;
    logic                    dispatch;
    logic                    restart;
  } trap_state_t;

endpackage : fault_trap_pkg

// File: src/fault_trap_unit.sv
/*
  Fault recording and user trap validation inside the core.
  Assumes decoder, memory interface and privilege inputs share the core
  clock and that CPU restart drives resetn.
*/
// Chosen here: the strobed register port and the address map.
// Functional notes
// - Vectors 32 to 127, 96 of them, are the user-configurable traps.
// - Only privilege 0 code may install a user trap, which is taken on a matching trap number.
// - Privilege 1 code may take a user trap only if its entry allows both levels.
// - A fault while the control halt bit is set halts the core until restart.
// - A fault that is not handled halts the core until restart.
// - Bit 0 records a machine check: bus failure, unrecoverable state or bad base task.
// - Bit 1 records an invalid memory operand of a memory instruction.
// - Bit 2 records a nonexistent register named by a valid opcode.
// - Bit 3 records an unexpected value written to a register.
// - Bit 4 records an operand value the instruction cannot process, such as entry above 127.
// - A fault during a built-in handler sets bit 13 and stores the handler id in byte 3.
// - On handler return the faulting instruction is restarted.
`include "fault_trap_cfg.svh"

module fault_trap_unit
  import fault_trap_pkg::*;
(
  input  wire logic        clock,            // Core clock, 200 MHz
  input  wire logic        resetn,           // Sync reset, CPU restart
  input  wire logic [7:0]  regAddr,          // Register byte address
  input  wire logic [31:0] regWrData,        // Register write data
  input  wire logic        regWr,            // Register write strobe
  input  wire logic        regRd,            // Register read strobe
  output logic      [31:0] regRdData,        // Read data, cycle after strobe
  input  wire logic        privLevel,        // Current privilege, 1 = level 1
  input  wire logic        trapReq,          // Trap instruction executed
  input  wire logic [7:0]  trapNum,          // Trap operand
  input  wire logic        vecWrReq,         // Vector modification request
  input  wire logic [7:0]  vecWrNum,         // Entry to modify
  input  wire logic        vecWrAllowBoth,   // Entry allows both levels
  input  wire logic        busFail,          // System bus failure
  input  wire logic        unrecoverable,    // Unrecoverable state found
  input  wire logic        baseTaskBad,      // Base task not privilege 0
  input  wire logic        badMemOperand,    // Invalid memory operand
  input  wire logic        badRegId,         // Nonexistent register id
  input  wire logic        badRegValue,      // Unexpected register value
  input  wire logic        badOperandValue,  // Unprocessable operand
  input  wire logic        archHandlerBusy,  // Built-in handler running
  input  wire logic [7:0]  archHandlerId,    // Its interrupt id
  input  wire logic        handlerReturn,    // Fault handler returned
  output logic             trapTake,         // Take user trap, pulse
  output logic      [6:0]  trapVecIndex,     // Entry number of taken trap
  output logic             trapDenied,       // Trap refused, pulse
  output logic             faultDispatch,    // Enter fault handler, pulse
  output logic      [31:0] handlerAddr,      // Fault handler address
  output logic             restartReq,       // Restart faulting instr, pulse
  output logic             halted,           // Core halted
  output logic      [31:0] faultFlags        // Fault flag register view
);

  // ========================================================================
  // Fault detection
  trap_state_t st_reg;
  trap_state_t st_next;
  logic [5:0]  flagSet;
  logic [5:0]  flagClr;
  logic [5:0]  flagQ;
  logic        vecOver;
  logic        anyFault;
  logic        userTrap;
  logic [6:0]  trapEntry;
  logic [6:0]  wrEntry;
  logic        flagWr;

  assign vecOver  = vecWrReq && (vecWrNum > `USER_LAST);
  assign flagSet[0] = busFail | unrecoverable | baseTaskBad;
  assign flagSet[1] = badMemOperand;
  assign flagSet[2] = badRegId;
  assign flagSet[3] = badRegValue;
  assign flagSet[4] = badOperandValue | vecOver;
  assign anyFault   = |flagSet[4:0];
  assign flagSet[5] = anyFault && archHandlerBusy;

  assign flagWr        = regWr && (regAddr == `OFF_FAULT_FLAG);
  // Write one to clear; a new fault in the same cycle still sets the bit
  assign flagClr[4:0]  = flagWr ? regWrData[4:0] : 5'h00;
  assign flagClr[5]    = flagWr && regWrData[`FF_SOFTWARE_TRAP_INSTRUCTION_FAULT];

  sticky_flags #(
    .W (6)
  ) u_flags (
    .clock   (clock),
    .resetn  (resetn),
    .setBits (flagSet),
    .clrBits (flagClr),
    .flags   (flagQ)
  );

  assign userTrap  = (trapNum >= `USER_FIRST) && (trapNum <= `USER_LAST);
  assign trapEntry = 7'(trapNum - `USER_FIRST);
  assign wrEntry   = 7'(vecWrNum - `USER_FIRST);

  // ========================================================================
  // Next state
  always_comb begin
    st_next            = st_reg;
    st_next.trapTake   = 1'b0;
    st_next.trapDenied = 1'b0;
    st_next.dispatch   = 1'b0;
    st_next.restart    = 1'b0;

    // Register writes
    if (regWr) begin
      case (regAddr)
        `OFF_CTRL:    st_next.haltOnFault = regWrData[`CTRL_HALT_BIT];
        `OFF_HANDLER: st_next.handlerAddr = regWrData;
        default:      st_next.haltOnFault = st_reg.haltOnFault;
      endcase
    end

    // Interrupt id byte follows the bit 13 flag
    if (flagSet[5]) begin
      st_next.faultId = archHandlerId;
    end else if (flagClr[5]) begin
      st_next.faultId = 8'h00;
    end

    case (st_reg.mode)
      MODE_RUN: begin
        if (anyFault) begin
          // Machine check cannot be handled
          if (flagSet[0] || st_reg.haltOnFault) begin
            st_next.mode = MODE_HALT;
          end else begin
            st_next.mode     = MODE_HANDLER;
            st_next.dispatch = 1'b1;
          end
        end else begin
          if (vecWrReq && !privLevel && (vecWrNum >= `USER_FIRST) &&
              (vecWrNum <= `USER_LAST)) begin
            st_next.vecValid[wrEntry] = 1'b1;
            st_next.vecBoth[wrEntry]  = vecWrAllowBoth;
          end
          if (trapReq && userTrap) begin
            if (st_reg.vecValid[trapEntry] &&
                (!privLevel || st_reg.vecBoth[trapEntry])) begin
              st_next.trapTake = 1'b1;
              st_next.trapIdx  = trapEntry;
            end else begin
              st_next.trapDenied = 1'b1;
            end
          end
        end
      end
      MODE_HANDLER: begin
        if (anyFault) begin
          // A fault inside the handler has nowhere to go
          st_next.mode = MODE_HALT;
        end else if (handlerReturn) begin
          st_next.mode    = MODE_RUN;
          st_next.restart = 1'b1;
        end
      end
      MODE_HALT: begin
        st_next.mode = MODE_HALT;
      end
      default: begin
        st_next.mode = MODE_HALT;
      end
    endcase

    // Read data, valid only in the cycle after the strobe
    st_next.rdData = 32'h0000_0000;
    if (regRd) begin
      case (regAddr)
        `OFF_CTRL:       st_next.rdData[`CTRL_HALT_BIT] = st_reg.haltOnFault;
        `OFF_FAULT_FLAG: st_next.rdData = faultFlags;
        `OFF_HANDLER:    st_next.rdData = st_reg.handlerAddr;
        `OFF_STATUS: begin
          st_next.rdData[`ST_HALTED_BIT]  = (st_reg.mode == MODE_HALT);
          st_next.rdData[`ST_HANDLER_BIT] = (st_reg.mode == MODE_HANDLER);
        end
        default:         st_next.rdData = 32'h0000_0000;
      endcase
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_reg             <= '0;
      st_reg.mode        <= MODE_RUN;
      st_reg.haltOnFault <= `CTRL_RESET;
      st_reg.handlerAddr <= `HANDLER_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ========================================================================
  // Outputs
  always_comb begin
    faultFlags                    = 32'h0000_0000;
    faultFlags[4:0]               = flagQ[4:0];
    faultFlags[`FF_SOFTWARE_TRAP_INSTRUCTION_FAULT]    = flagQ[5];
    faultFlags[31:`FF_ID_LSB]     = st_reg.faultId;
  end

  assign regRdData     = st_reg.rdData;
  assign trapTake      = st_reg.trapTake;
  assign trapVecIndex  = st_reg.trapIdx;
  assign trapDenied    = st_reg.trapDenied;
  assign faultDispatch = st_reg.dispatch;
  assign restartReq    = st_reg.restart;
  assign handlerAddr   = st_reg.handlerAddr;
  assign halted        = (st_reg.mode == MODE_HALT);

  // ========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_dispatchPulse;
    faultDispatch ##1 !faultDispatch;
  endsequence

  sequence s_handlerEntered;
    (st_reg.mode == MODE_HANDLER) && !halted;
  endsequence

  property p_user_take;
    (st_reg.mode == MODE_RUN) && !anyFault && trapReq && userTrap && !privLevel &&
      st_reg.vecValid[trapEntry]
    |=> trapTake && (trapVecIndex == $past(trapEntry)) && !trapDenied;
  endproperty
  a_user_take: assert property (p_user_take)
    else $error("valid user trap not taken");

  property p_install_priv;
    (st_reg.mode == MODE_RUN) && vecWrReq && privLevel |=> $stable(st_reg.vecValid);
  endproperty
  a_install_priv: assert property (p_install_priv)
    else $error("privilege 1 code installed a trap");

  property p_priv1_deny;
    (st_reg.mode == MODE_RUN) && !anyFault && trapReq && userTrap && privLevel &&
      !st_reg.vecBoth[trapEntry]
    |=> trapDenied && !trapTake;
  endproperty
  a_priv1_deny: assert property (p_priv1_deny)
    else $error("privilege 1 trap not refused");

  property p_halt_ctrl;
    (st_reg.mode == MODE_RUN) && anyFault && st_reg.haltOnFault |=> halted [*3];
  endproperty
  a_halt_ctrl: assert property (p_halt_ctrl)
    else $error("fault with halt bit did not halt");

  property p_dispatch;
    (st_reg.mode == MODE_RUN) && anyFault && !st_reg.haltOnFault && !flagSet[0]
    |=> s_dispatchPulse and s_handlerEntered;
  endproperty
  a_dispatch: assert property (p_dispatch)
    else $error("handled fault not dispatched");

  property p_nested_halt;
    (st_reg.mode == MODE_HANDLER) && anyFault |=> halted ##1 halted && !faultDispatch;
  endproperty
  a_nested_halt: assert property (p_nested_halt)
    else $error("fault in handler did not halt");

  property p_mcheck;
    (st_reg.mode == MODE_RUN) && (busFail || baseTaskBad) |=> halted && faultFlags[0];
  endproperty
  a_mcheck: assert property (p_mcheck)
    else $error("machine check not halting");

  property p_badmem;
    badMemOperand |=> faultFlags[1];
  endproperty
  a_badmem: assert property (p_badmem)
    else $error("bad memory operand not flagged");

  property p_regid;
    badRegId |=> faultFlags[2];
  endproperty
  a_regid: assert property (p_regid)
    else $error("bad register id not flagged");

  property p_regval;
    badRegValue |=> faultFlags[3];
  endproperty
  a_regval: assert property (p_regval)
    else $error("bad register value not flagged");

  property p_oversize;
    vecWrReq && (vecWrNum > 8'h7F) |=> faultFlags[4];
  endproperty
  a_oversize: assert property (p_oversize)
    else $error("entry above 127 not flagged");

  property p_arch;
    anyFault && archHandlerBusy
    |=> faultFlags[13] && (faultFlags[31:24] == $past(archHandlerId));
  endproperty
  a_arch: assert property (p_arch)
    else $error("handler fault id not recorded");

  property p_restart;
    (st_reg.mode == MODE_HANDLER) && !anyFault && handlerReturn
    |=> restartReq ##1 !restartReq && !halted;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart not issued on return");

  property p_sticky;
    faultFlags[2] && !(flagWr && regWrData[2]) |=> faultFlags[2];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("fault flag lost without clear");

  property p_set_wins;
    flagWr && regWrData[1] && badMemOperand |=> faultFlags[1];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a new fault");

endmodule : fault_trap_unit

// File: src/sticky_flags.sv
/*
  Bank of sticky flags: a set wins over a clear in the same cycle.
  Assumes set and clear come from logic on the same clock.
*/
module sticky_flags #(
  parameter int W = 1
) (
  input  wire logic         clock,   // Core clock
  input  wire logic         resetn,  // Sync reset, active low
  input  wire logic [W-1:0] setBits, // Per-bit set pulse
  input  wire logic [W-1:0] clrBits, // Per-bit clear pulse
  output logic      [W-1:0] flags    // Held flags
);

  typedef struct packed {
    logic [W-1:0] flags;
  } flag_state_t;

  flag_state_t st_reg;
  flag_state_t st_next;

  always_comb begin
    st_next       = st_reg;
    st_next.flags = (st_reg.flags & ~clrBits) | setBits;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flags = st_reg.flags;

endmodule : sticky_flags

// File: tb/fault_trap_unit_tb.sv
/*
  Self-checking bench for the fault and user trap unit: register port,
  trap validation, vector install, fault recording, dispatch and halt.
  Assumes the package and fault_trap_cfg.svh are compiled before it.
*/
`include "fault_trap_cfg.svh"

module fault_trap_unit_tb
  import fault_trap_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Signals
  logic        clock;
  logic        resetn;
  logic [7:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdData;
  logic        privLevel;
  logic        trapReq;
  logic [7:0]  trapNum;
  logic        vecWrReq;
  logic [7:0]  vecWrNum;
  logic        vecWrAllowBoth;
  logic [6:0]  faultVec;
  logic        archHandlerBusy;
  logic [7:0]  archHandlerId;
  logic        handlerReturn;
  logic        trapTake;
  logic [6:0]  trapVecIndex;
  logic        trapDenied;
  logic        faultDispatch;
  logic [31:0] handlerAddr;
  logic        restartReq;
  logic        halted;
  logic [31:0] faultFlags;
  logic        inst [0:127];
  logic        both [0:127];
  int          nErrors;
  int          cmpCount;
  int          seed;
  int          i;
  logic [7:0]  n;
  logic        p;
  logic        b;
  logic [31:0] d;

  fault_trap_unit u_fault_trap_unit (
    .clock(clock), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .privLevel(privLevel),
    .trapReq(trapReq), .trapNum(trapNum), .vecWrReq(vecWrReq), .vecWrNum(vecWrNum),
    .vecWrAllowBoth(vecWrAllowBoth), .busFail(faultVec[0]), .unrecoverable(faultVec[1]),
    .baseTaskBad(faultVec[2]), .badMemOperand(faultVec[3]), .badRegId(faultVec[4]),
    .badRegValue(faultVec[5]), .badOperandValue(faultVec[6]),
    .archHandlerBusy(archHandlerBusy), .archHandlerId(archHandlerId),
    .handlerReturn(handlerReturn), .trapTake(trapTake), .trapVecIndex(trapVecIndex),
    .trapDenied(trapDenied), .faultDispatch(faultDispatch), .handlerAddr(handlerAddr),
    .restartReq(restartReq), .halted(halted), .faultFlags(faultFlags)
  );

  always #2.5 clock = ~clock;

  // ==========================================================================
  // Checking helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nErrors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Order: take, denied, dispatch, restart, halted
  task automatic outs(input logic [4:0] e);
    chk({27'h0, trapTake, trapDenied, faultDispatch, restartReq, halted}, {27'h0, e});
  endtask : outs

  function automatic logic [1:0] trapExp(input logic [7:0] num, input logic pl);
    if (num < `USER_FIRST || num > `USER_LAST) return 2'b00;
    if (!inst[num[6:0]]) return 2'b01;
    if (pl && !both[num[6:0]]) return 2'b01;
    return 2'b10;
  endfunction : trapExp

  task automatic stopTest();
    if (nErrors == 0 && cmpCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stopTest

  // ==========================================================================
  // Drivers: request after one edge, sampled at the next
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    regAddr <= a;
    regWrData <= wd;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    chk(regRdData, e);
  endtask : rd

  task automatic trap(input logic [7:0] num, input logic pl, input logic [1:0] e);
    @(posedge clock);
    trapReq <= 1'b1;
    trapNum <= num;
    privLevel <= pl;
    @(posedge clock);
    trapReq <= 1'b0;
    #1;
    chk({30'h0, trapTake, trapDenied}, {30'h0, e});
    if (e[1]) chk({25'h0, trapVecIndex}, {25'h0, 7'(num - `USER_FIRST)});
  endtask : trap

  task automatic vecw(input logic [7:0] num, input logic bb, input logic pl);
    @(posedge clock);
    vecWrReq <= 1'b1;
    vecWrNum <= num;
    vecWrAllowBoth <= bb;
    privLevel <= pl;
    @(posedge clock);
    vecWrReq <= 1'b0;
    #1;
    if (!pl && num >= `USER_FIRST && num <= `USER_LAST) begin
      inst[num[6:0]] = 1'b1;
      both[num[6:0]] = bb;
    end
  endtask : vecw

  task automatic fault(input logic [6:0] f);
    @(posedge clock);
    faultVec <= f;
    @(posedge clock);
    faultVec <= 7'h00;
    #1;
  endtask : fault

  task automatic ret();
    @(posedge clock);
    handlerReturn <= 1'b1;
    @(posedge clock);
    handlerReturn <= 1'b0;
    #1;
  endtask : ret

  // CPU restart also empties the vector table
  task automatic restart();
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    #1;
    for (int k = 0; k < 128; k++) begin
      inst[k] = 1'b0;
      both[k] = 1'b0;
    end
    outs(5'b00000);
    chk(faultFlags, 32'h0000_0000);
  endtask : restart

  // ==========================================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    nErrors++;
    stopTest();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    clock = 1'b0; resetn = 1'b0; regAddr = 8'h00; regWrData = 32'h0; regWr = 1'b0;
    regRd = 1'b0; privLevel = 1'b0; trapReq = 1'b0; trapNum = 8'h00; vecWrReq = 1'b0;
    vecWrNum = 8'h00; vecWrAllowBoth = 1'b0; faultVec = 7'h00; archHandlerBusy = 1'b0;
    archHandlerId = 8'h00; handlerReturn = 1'b0; nErrors = 0; cmpCount = 0; seed = 1;
    for (int k = 0; k < 128; k++) begin
      inst[k] = 1'b0;
      both[k] = 1'b0;
    end
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    #1;
    outs(5'b00000);
    rd(`OFF_CTRL, 32'h0);
    rd(`OFF_FAULT_FLAG, 32'h0);
    rd(`OFF_HANDLER, `HANDLER_RESET);
    rd(`OFF_STATUS, 32'h0);
    d = $random(seed);
    wr(`OFF_HANDLER, d);
    wr(8'h10, 32'hFFFF_FFFF);
    wr(`OFF_STATUS, 32'hFFFF_FFFF);
    rd(`OFF_HANDLER, d);
    chk(handlerAddr, d);
    // Read data stands one cycle only
    @(posedge clock);
    #1;
    chk(regRdData, 32'h0);
    rd(8'h10, 32'h0);
    rd(`OFF_STATUS, 32'h0);
    // Trap corners: empty table, numbers outside the user range
    trap(8'h25, 1'b0, 2'b01);
    trap(8'h1F, 1'b0, 2'b00);
    trap(8'h80, 1'b0, 2'b00);
    vecw(8'h20, 1'b0, 1'b0);
    vecw(8'h7F, 1'b1, 1'b0);
    vecw(8'h30, 1'b1, 1'b1);
    vecw(8'h1F, 1'b1, 1'b0);
    chk(faultFlags, 32'h0);
    trap(8'h20, 1'b0, 2'b10);
    trap(8'h20, 1'b1, 2'b01);
    trap(8'h7F, 1'b1, 2'b10);
    trap(8'h30, 1'b0, 2'b01);
    trap(8'h1F, 1'b0, 2'b00);
    for (i = 0; i < 40; i++) begin
      n = 8'h20 + 8'($unsigned($random(seed)) % 96);
      p = 1'($random(seed));
      b = 1'($random(seed));
      if ($random(seed) & 1) vecw(n, b, p);
      else trap(n, p, trapExp(n, p));
    end
    // Entry above the table: operand fault, handed to the handler
    vecw(8'h80, 1'b0, 1'b0);
    chk(faultFlags, 32'h0000_0010);
    outs(5'b00100);
    rd(`OFF_STATUS, 32'h2);
    trap(8'h20, 1'b0, 2'b00);
    ret();
    outs(5'b00010);
    wr(`OFF_FAULT_FLAG, 32'h0000_0010);
    rd(`OFF_FAULT_FLAG, 32'h0);
    // Two faults at once, then a third: all stay recorded
    fault(7'h28);
    chk(faultFlags, 32'h0000_000A);
    outs(5'b00100);
    ret();
    fault(7'h10);
    chk(faultFlags, 32'h0000_000E);
    ret();
    wr(`OFF_FAULT_FLAG, 32'h0000_0002);
    rd(`OFF_FAULT_FLAG, 32'h0000_000C);
    wr(`OFF_FAULT_FLAG, 32'hFFFF_FFFF);
    rd(`OFF_FAULT_FLAG, 32'h0);
    // Clear and new fault on one edge: the fault must survive
    @(posedge clock);
    faultVec  <= 7'h08;
    regAddr   <= `OFF_FAULT_FLAG;
    regWrData <= 32'h0000_0002;
    regWr     <= 1'b1;
    @(posedge clock);
    faultVec  <= 7'h00;
    regWr     <= 1'b0;
    #1;
    chk(faultFlags, 32'h0000_0002);
    outs(5'b00100);
    ret();
    wr(`OFF_FAULT_FLAG, 32'hFFFF_FFFF);
    rd(`OFF_FAULT_FLAG, 32'h0);
    // Fault inside a built-in handler records its id
    @(posedge clock);
    archHandlerBusy <= 1'b1;
    archHandlerId <= 8'h0B;
    fault(7'h40);
    chk(faultFlags, 32'h0B00_2010);
    @(posedge clock);
    archHandlerBusy <= 1'b0;
    ret();
    wr(`OFF_FAULT_FLAG, 32'h0000_2010);
    rd(`OFF_FAULT_FLAG, 32'h0);
    // Second fault while handling is unhandled: halt until restart
    fault(7'h10);
    fault(7'h08);
    outs(5'b00001);
    repeat (10) @(posedge clock);
    ret();
    outs(5'b00001);
    trap(8'h7F, 1'b0, 2'b00);
    restart();
    // Halt-on-fault control bit
    wr(`OFF_CTRL, 32'h0000_0002);
    rd(`OFF_CTRL, 32'h0000_0002);
    fault(7'h20);
    chk(faultFlags, 32'h0000_0008);
    outs(5'b00001);
    restart();
    rd(`OFF_CTRL, 32'h0);
    trap(8'h20, 1'b0, 2'b01);
    // Each machine check cause halts with the control bit clear
    for (i = 0; i < 3; i++) begin
      fault(7'(1 << i));
      chk(faultFlags, 32'h0000_0001);
      outs(5'b00001);
      restart();
    end
    stopTest();
  end

endmodule : fault_trap_unit_tb
